// ---- sasr_regs.sv ----
// Behaviour
// - Word-aligned bit per lane in low nibble of each quad alignment status.
// - Group-aligned bit per lane in high nibble of same status register.
// - Pair FIFO overflow flag per channel pair, bits 0 and 1.
// - Quad FIFO overflow flag in bit 2.
// - Pair out-of-sync flag per pair, bits 3 and 4.
// - Quad out-of-sync flag in bit 5.
// - Two-bit transmit clock source select per quad, 00/10/01/11 lanes A-D.
// - Two-bit receive clock source select per quad, same encoding.
// - Threshold low three bits from bits 5..7 of second common register.
// - Threshold high two bits from bits 0..1 of third common register.
// - All eight lanes resync on rising edge of resync control bit.
// - Octal FIFO overflow flag read-only in bit 0 of common status.
// - Octal out-of-sync flag read-only in bit 1 of common status.
// - All flags, selectors, threshold and resync control reset to zero.
// - In group alignment each lane keeps its own clock up to alignment.
// - Lane contributes to group alignment only while participation enabled.
// - Per-lane group size 00 none, 10 two, 01 four, 11 eight.
//
// Our own choice: the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module sasr_regs
(
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [7:0] wordAlignedIn,
  input wire logic [7:0] laneAlignedIn,
  input wire logic [3:0] pairOverflowIn,
  input wire logic [1:0] quadOverflowIn,
  input wire logic [3:0] pairOutOfSyncIn,
  input wire logic [1:0] quadOutOfSyncIn,
  input wire logic octalOverflowIn,
  input wire logic octalOutOfSyncIn,
  output logic [7:0] clockSourceSel,
  output logic [4:0] rxFifoThreshold,
  output logic allLanesResync,
  output logic [7:0] laneParticipateEn,
  output logic [15:0] laneGroupSize,
  output logic irq
);
  import sasr_pkg::*;

  // ****************************************************************
  // Bus decode.
  // ****************************************************************
  // Status inputs are synchronous to ref_clk: each lane's recovered
  // clock domain is crossed before it reaches this bank.
  logic [19:0] regIdx;
  logic setupCycle;
  logic wrEn;
  logic mapped;
  logic [7:0] quadAAlign;
  logic [7:0] quadBAlign;
  logic [7:0] quadAGrp;
  logic [7:0] quadBGrp;
  logic [7:0] octalStat;
  logic [7:0] thrLo_r;
  logic [7:0] thrHi_r;
  logic [7:0] irqStat_r;
  logic [7:0] irqMask_r;
  logic [7:0] events;
  logic resyncPrev_r;
  logic [31:0] rdNxt;
  logic rdFirst;

  assign regIdx = paddr[21:2];
  assign setupCycle = psel && !penable;
  assign rdFirst = psel && penable && !pready && !pwrite;
  assign wrEn = psel && penable && pwrite && pready && pstrb[0];

  always_comb
  begin
    case (regIdx)
      SASR_IDX_QA_ALIGN, SASR_IDX_QA_GRP, SASR_IDX_QB_ALIGN, SASR_IDX_QB_GRP,
      SASR_IDX_CLKSEL, SASR_IDX_THR_LO, SASR_IDX_THR_HI, SASR_IDX_OCT,
      SASR_IDX_IRQ_STAT, SASR_IDX_IRQ_MASK, SASR_IDX_LANE_CTL,
      SASR_IDX_LANE_MODE: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end

  // ****************************************************************
  // Status assembly.
  // ****************************************************************
  // A lane reports group alignment only while it participates.
  genvar g;
  generate
    for (g = 0; g < 4; g++)
    begin : gLane
      assign quadAAlign[g] = wordAlignedIn[g];
      assign quadBAlign[g] = wordAlignedIn[g+4];
      assign quadAAlign[g+4] = laneAlignedIn[g] && laneParticipateEn[g]
        && (laneGroupSize[2*g +: 2] != SASR_GRP_NONE);
      assign quadBAlign[g+4] = laneAlignedIn[g+4] && laneParticipateEn[g+4]
        && (laneGroupSize[2*(g+4) +: 2] != SASR_GRP_NONE);
    end
  endgenerate

  assign quadAGrp = {2'b00, quadOutOfSyncIn[0], pairOutOfSyncIn[1:0],
    quadOverflowIn[0], pairOverflowIn[1:0]};
  assign quadBGrp = {2'b00, quadOutOfSyncIn[1], pairOutOfSyncIn[3:2],
    quadOverflowIn[1], pairOverflowIn[3:2]};
  assign octalStat = {6'h00, octalOutOfSyncIn, octalOverflowIn};

  // Sticky events, bit 0 up: quad group bits, octal pair, then lane and word alignment summaries.
  assign events = {|wordAlignedIn, |laneAlignedIn, 2'b00,
    octalOutOfSyncIn, octalOverflowIn, |(quadBGrp & SASR_GRP_USED),
    |(quadAGrp & SASR_GRP_USED)};

  always_comb
  begin
    rdNxt = 32'h0000_0000;
    case (regIdx)
      SASR_IDX_QA_ALIGN: rdNxt[7:0] = quadAAlign;
      SASR_IDX_QA_GRP: rdNxt[7:0] = quadAGrp;
      SASR_IDX_QB_ALIGN: rdNxt[7:0] = quadBAlign;
      SASR_IDX_QB_GRP: rdNxt[7:0] = quadBGrp;
      SASR_IDX_CLKSEL: rdNxt[7:0] = clockSourceSel;
      SASR_IDX_THR_LO: rdNxt[7:0] = thrLo_r;
      SASR_IDX_THR_HI: rdNxt[7:0] = thrHi_r;
      SASR_IDX_OCT: rdNxt[7:0] = octalStat;
      SASR_IDX_IRQ_STAT: rdNxt[7:0] = irqStat_r;
      SASR_IDX_IRQ_MASK: rdNxt[7:0] = irqMask_r;
      SASR_IDX_LANE_CTL: rdNxt[7:0] = laneParticipateEn;
      SASR_IDX_LANE_MODE: rdNxt[15:0] = laneGroupSize;
      default: rdNxt = 32'h0000_0000;
    endcase
  end

  // ****************************************************************
  // Bus answer: one wait state, pready high in the second access cycle.
  // ****************************************************************
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end
    else
    begin
      pready <= psel && penable && !pready;
      pslverr <= psel && penable && !pready && !mapped;
      if (psel && penable && !pready && !pwrite)
        prdata <= rdNxt;
    end
  end

  // ****************************************************************
  // Writable registers.
  // ****************************************************************
  // Only implemented bits are stored; the rest read zero.
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      clockSourceSel <= SASR_RESET_VAL;
      thrLo_r <= SASR_RESET_VAL;
      thrHi_r <= SASR_RESET_VAL;
      irqMask_r <= SASR_RESET_VAL;
      laneParticipateEn <= SASR_RESET_VAL;
      laneGroupSize <= 16'h0000;
    end
    else if (wrEn && mapped)
    begin
      case (regIdx)
        SASR_IDX_CLKSEL: clockSourceSel <= pwdata[7:0];
        SASR_IDX_THR_LO: thrLo_r <= {pwdata[7:5], 5'h00};
        SASR_IDX_THR_HI: thrHi_r <= {5'h00, pwdata[2:0]};
        SASR_IDX_IRQ_MASK: irqMask_r <= pwdata[7:0];
        SASR_IDX_LANE_CTL: laneParticipateEn <= pwdata[7:0];
        SASR_IDX_LANE_MODE:
        begin
          if (pstrb[1])
            laneGroupSize <= pwdata[15:0];
        end
        default: ;
      endcase
    end
  end

  // Threshold LSb is bit 5; values above 17 are software's concern.
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
      rxFifoThreshold <= 5'h00;
    else
      rxFifoThreshold <= {thrHi_r[1:0], thrLo_r[7:SASR_THR_LO_POS]};
  end

  // ****************************************************************
  // Eight-lane resync: one pulse per 0-to-1 transition, not per level.
  // ****************************************************************
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      resyncPrev_r <= 1'b0;
      allLanesResync <= 1'b0;
    end
    else
    begin
      resyncPrev_r <= thrHi_r[SASR_RESYNC_POS];
      allLanesResync <= thrHi_r[SASR_RESYNC_POS] && !resyncPrev_r;
    end
  end

  // ****************************************************************
  // Interrupt status: write one to clear; a new event wins the clear.
  // ****************************************************************
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
      irqStat_r <= SASR_RESET_VAL;
    else if (wrEn && regIdx == SASR_IDX_IRQ_STAT)
      irqStat_r <= (irqStat_r & ~pwdata[7:0]) | events;
    else
      irqStat_r <= irqStat_r | events;
  end

  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
      irq <= 1'b0;
    else
      irq <= |(irqStat_r & irqMask_r);
  end

  // ****************************************************************
  // Checks.
  // ****************************************************************
  // The resync pulse and the bus answer are each high for one cycle only.
  sequence s_resync_pulse;
    allLanesResync ##1 !allLanesResync;
  endsequence

  sequence s_access_start;
    psel && penable && !pready;
  endsequence

  sequence s_answer;
    pready ##1 !pready;
  endsequence

  property p_resync_edge;
    @(posedge ref_clk) disable iff (!arst_n)
    $rose(thrHi_r[SASR_RESYNC_POS]) |=> s_resync_pulse;
  endproperty
  a_resync_edge: assert property (p_resync_edge) else $error("resync pulse wrong");

  property p_resync_level;
    @(posedge ref_clk) disable iff (!arst_n)
    allLanesResync |-> $past(thrHi_r[SASR_RESYNC_POS]) && !$past(resyncPrev_r);
  endproperty
  a_resync_level: assert property (p_resync_level) else $error("resync without edge");

  property p_thr;
    @(posedge ref_clk) disable iff (!arst_n)
    ##1 rxFifoThreshold == {$past(thrHi_r[1:0]), $past(thrLo_r[7:5])};
  endproperty
  a_thr: assert property (p_thr) else $error("threshold mismatch");

  property p_participate;
    @(posedge ref_clk) disable iff (!arst_n)
    rdFirst && regIdx == SASR_IDX_QA_ALIGN && !laneParticipateEn[0] |=> !prdata[4];
  endproperty
  a_participate: assert property (p_participate) else $error("lane aligned w/o enable");

  property p_word;
    @(posedge ref_clk) disable iff (!arst_n)
    rdFirst && regIdx == SASR_IDX_QB_ALIGN |=> prdata[3:0] == $past(wordAlignedIn[7:4]);
  endproperty
  a_word: assert property (p_word) else $error("word aligned map");

  property p_grp_reserved;
    @(posedge ref_clk) disable iff (!arst_n)
    rdFirst && regIdx == SASR_IDX_QA_GRP |=> prdata[31:6] == 26'h0;
  endproperty
  a_grp_reserved: assert property (p_grp_reserved) else $error("reserved set");

  property p_octal;
    @(posedge ref_clk) disable iff (!arst_n)
    rdFirst && regIdx == SASR_IDX_OCT |=>
      prdata == {30'h0, $past(octalOutOfSyncIn), $past(octalOverflowIn)};
  endproperty
  a_octal: assert property (p_octal) else $error("octal status map");

  property p_quad_grp;
    @(posedge ref_clk) disable iff (!arst_n)
    rdFirst && regIdx == SASR_IDX_QB_GRP |=> prdata[5:2] ==
      {$past(quadOutOfSyncIn[1]), $past(pairOutOfSyncIn[3:2]), $past(quadOverflowIn[1])};
  endproperty
  a_quad_grp: assert property (p_quad_grp) else $error("quad group map");

  property p_clksel;
    @(posedge ref_clk) disable iff (!arst_n)
    wrEn && regIdx == SASR_IDX_CLKSEL |=> clockSourceSel == $past(pwdata[7:0]);
  endproperty
  a_clksel: assert property (p_clksel) else $error("clock select write lost");

  // ****************************************************************
  // Bus protocol and threshold write checks.
  // ****************************************************************
  property p_answer;
    @(posedge ref_clk) disable iff (!arst_n)
    s_access_start |=> s_answer;
  endproperty
  a_answer: assert property (p_answer) else $error("bus answer is not one pulse");

  property p_setup_wait;
    @(posedge ref_clk) disable iff (!arst_n)
    setupCycle |=> !pready;
  endproperty
  a_setup_wait: assert property (p_setup_wait) else $error("ready after setup cycle");

  property p_err_ready;
    @(posedge ref_clk) disable iff (!arst_n)
    pslverr |-> pready;
  endproperty
  a_err_ready: assert property (p_err_ready) else $error("error without ready");

  property p_unmapped;
    @(posedge ref_clk) disable iff (!arst_n)
    rdFirst && !mapped |=> prdata == 32'h0000_0000 && pslverr;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read answer");

  property p_thr_lo_write;
    @(posedge ref_clk) disable iff (!arst_n)
    wrEn && regIdx == SASR_IDX_THR_LO |=> thrLo_r == {$past(pwdata[7:5]), 5'h00};
  endproperty
  a_thr_lo_write: assert property (p_thr_lo_write) else $error("low threshold write");

  property p_thr_hi_write;
    @(posedge ref_clk) disable iff (!arst_n)
    wrEn && regIdx == SASR_IDX_THR_HI |=> thrHi_r == {5'h00, $past(pwdata[2:0])};
  endproperty
  a_thr_hi_write: assert property (p_thr_hi_write) else $error("high threshold write");

  // ****************************************************************
  // Interrupt checks.
  // ****************************************************************
  // A pending event must survive a clear that falls in the same cycle.
  property p_irq_on;
    @(posedge ref_clk) disable iff (!arst_n)
    (irqStat_r & irqMask_r) != 8'h00 |=> irq;
  endproperty
  a_irq_on: assert property (p_irq_on) else $error("interrupt not raised");

  property p_irq_off;
    @(posedge ref_clk) disable iff (!arst_n)
    (irqStat_r & irqMask_r) == 8'h00 |=> !irq;
  endproperty
  a_irq_off: assert property (p_irq_off) else $error("interrupt not dropped");

  property p_set_wins;
    @(posedge ref_clk) disable iff (!arst_n)
    events != 8'h00 |=> (irqStat_r & $past(events)) == $past(events);
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("event lost in status");

  property p_sticky;
    @(posedge ref_clk) disable iff (!arst_n)
    !(wrEn && regIdx == SASR_IDX_IRQ_STAT) |=>
      (irqStat_r & $past(irqStat_r)) == $past(irqStat_r);
  endproperty
  a_sticky: assert property (p_sticky) else $error("status bit dropped");

endmodule
`default_nettype wire

// ---- sasr_pkg.sv ----
package sasr_pkg;

  // ****************************************************************
  // Register word indices (printed offsets are not all word aligned,
  // so each printed offset is an index and the byte address is 4x).
  // ****************************************************************
  localparam logic [19:0] SASR_IDX_QA_ALIGN = 20'h30805;
  localparam logic [19:0] SASR_IDX_QA_GRP = 20'h30814;
  localparam logic [19:0] SASR_IDX_QB_ALIGN = 20'h30905;
  localparam logic [19:0] SASR_IDX_QB_GRP = 20'h30914;
  localparam logic [19:0] SASR_IDX_CLKSEL = 20'h30A00;
  localparam logic [19:0] SASR_IDX_THR_LO = 20'h30A01;
  localparam logic [19:0] SASR_IDX_THR_HI = 20'h30A02;
  localparam logic [19:0] SASR_IDX_OCT = 20'h30A03;
  localparam logic [19:0] SASR_IDX_IRQ_STAT = 20'h30A10;
  localparam logic [19:0] SASR_IDX_IRQ_MASK = 20'h30A11;
  localparam logic [19:0] SASR_IDX_LANE_CTL = 20'h30A12;
  localparam logic [19:0] SASR_IDX_LANE_MODE = 20'h30A13;

  // ****************************************************************
  // Field positions and reset values.
  // ****************************************************************
  localparam int SASR_THR_LO_POS = 5;
  localparam int SASR_RESYNC_POS = 2;
  localparam logic [7:0] SASR_RESET_VAL = 8'h00;
  localparam logic [7:0] SASR_GRP_USED = 8'h3F;
  localparam logic [7:0] SASR_OCT_USED = 8'h03;
  localparam logic [4:0] SASR_THR_MAX = 5'h11;

  // Group sizes of a lane.
  typedef enum logic [1:0]
  {
    SASR_GRP_NONE = 2'b00,
    SASR_GRP_FOUR = 2'b01,
    SASR_GRP_TWO = 2'b10,
    SASR_GRP_EIGHT = 2'b11
  } sasr_grp_t;

endpackage

// ---- sasr_regs_bench.sv ----
`timescale 1ns/1ps
`default_nettype none
module sasr_regs_bench;
  import sasr_pkg::*;
  logic refClk = 1'b0;
  logic arstN = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] paddr = 32'h0;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] strb = 4'hF;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [7:0] wordAl = 8'h00;
  logic [7:0] laneAl = 8'h00;
  logic [3:0] pairOv = 4'h0;
  logic [3:0] pairOos = 4'h0;
  logic [1:0] quadOv = 2'h0;
  logic [1:0] quadOos = 2'h0;
  logic octOv = 1'b0;
  logic octOos = 1'b0;
  logic [7:0] clkSel;
  logic [7:0] laneEn;
  logic [15:0] grpSize;
  logic [4:0] thr;
  logic resync;
  logic irq;
  logic [31:0] rd;
  logic err;
  int nFail = 0;
  int checks = 0;

  always #4 refClk = ~refClk;

  sasr_regs sasr_regs_inst (.ref_clk(refClk), .arst_n(arstN), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(strb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .wordAlignedIn(wordAl), .laneAlignedIn(laneAl),
    .pairOverflowIn(pairOv), .quadOverflowIn(quadOv), .pairOutOfSyncIn(pairOos),
    .quadOutOfSyncIn(quadOos), .octalOverflowIn(octOv), .octalOutOfSyncIn(octOos),
    .clockSourceSel(clkSel), .rxFifoThreshold(thr), .allLanesResync(resync),
    .laneParticipateEn(laneEn), .laneGroupSize(grpSize), .irq(irq));

  // ****************************************************************
  // Bus and checking helpers.
  // ****************************************************************
  task automatic results;
    $display("checks %0d mismatches %0d", checks, nFail);
    if (nFail == 0 && checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
      nFail++;
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge refClk);
  endtask

  // The request is held until pready is seen high, for up to 20 cycles; a longer wait ends the run as failed.
  task automatic apb(input logic wr, input logic [19:0] idx, input logic [15:0] d);
    int n;
    @(posedge refClk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {10'h000, idx, 2'b00};
    pwdata <= {16'h0000, d};
    @(posedge refClk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge refClk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1)
    begin
      nFail++;
      results();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rdchk(input string what, input logic [19:0] idx, input logic [31:0] exp);
    apb(1'b0, idx, 16'h0000);
    chk(what, rd, exp);
    chk("pslverr", {31'h0, err}, 32'h0);
  endtask

  task automatic pulses(output int n);
    n = 0;
    repeat (6)
    begin
      @(posedge refClk);
      if (resync === 1'b1)
        n++;
    end
  endtask

  // ****************************************************************
  // Scenarios.
  // ****************************************************************
  task automatic t_reset;
    logic [19:0] regs [8] = '{SASR_IDX_QA_ALIGN, SASR_IDX_QA_GRP, SASR_IDX_QB_ALIGN,
      SASR_IDX_QB_GRP, SASR_IDX_CLKSEL, SASR_IDX_THR_LO, SASR_IDX_THR_HI, SASR_IDX_OCT};
    chk("outs", {17'h0, clkSel, thr, resync, irq}, 32'h0);
    chk("outs2", {8'h0, laneEn, grpSize}, 32'h0);
    foreach (regs[i]) rdchk("resetReg", regs[i], 32'h0);
    $display("test reset done");
  endtask

  task automatic t_status;
    wordAl <= 8'hA5;
    laneAl <= 8'hFF;
    pairOv <= 4'b0110;
    quadOv <= 2'b10;
    pairOos <= 4'b1001;
    quadOos <= 2'b01;
    octOv <= 1'b1;
    octOos <= 1'b1;
    cyc(3);
    rdchk("qaAlign", SASR_IDX_QA_ALIGN, 32'h05);
    rdchk("qbAlign", SASR_IDX_QB_ALIGN, 32'h0A);
    rdchk("qaGrp", SASR_IDX_QA_GRP, 32'h2A);
    rdchk("qbGrp", SASR_IDX_QB_GRP, 32'h15);
    rdchk("octal", SASR_IDX_OCT, 32'h03);
    apb(1'b1, SASR_IDX_OCT, 16'h00FC);
    rdchk("octalRo", SASR_IDX_OCT, 32'h03);
    apb(1'b1, SASR_IDX_LANE_CTL, 16'h0001);
    cyc(1);
    chk("laneEn", {24'h0, laneEn}, 32'h01);
    for (int m = 0; m < 4; m++)
    begin
      apb(1'b1, SASR_IDX_LANE_MODE, 16'(m));
      cyc(2);
      chk("grpSize", {16'h0, grpSize}, 32'(m));
      rdchk("qaAlignMode", SASR_IDX_QA_ALIGN, (m != 0) ? 32'h15 : 32'h05);
    end
    rdchk("qbAlignOff", SASR_IDX_QB_ALIGN, 32'h0A);
    {wordAl, laneAl, pairOv, quadOv, pairOos, quadOos, octOv, octOos} <= '0;
    $display("test status done");
  endtask

  task automatic t_clk;
    logic [7:0] v [2] = '{8'h1B, 8'hE4};
    foreach (v[i])
    begin
      apb(1'b1, SASR_IDX_CLKSEL, {8'h00, v[i]});
      cyc(1);
      chk("clkSel", {24'h0, clkSel}, {24'h0, v[i]});
      rdchk("clkSelRd", SASR_IDX_CLKSEL, {24'h0, v[i]});
    end
    strb <= 4'h0;
    apb(1'b1, SASR_IDX_CLKSEL, 16'h0000);
    strb <= 4'hF;
    cyc(1);
    chk("clkSelStrb", {24'h0, clkSel}, 32'hE4);
    $display("test clock select done");
  endtask

  task automatic t_thr;
    int n;
    apb(1'b1, SASR_IDX_THR_LO, 16'h003F);
    apb(1'b1, SASR_IDX_THR_HI, 16'h00FA);
    cyc(2);
    chk("thrMax", {27'h0, thr}, {27'h0, SASR_THR_MAX});
    rdchk("thrLoRd", SASR_IDX_THR_LO, 32'h20);
    rdchk("thrHiRd", SASR_IDX_THR_HI, 32'h02);
    // The high bits go first so that the threshold never passes 17 on the way.
    apb(1'b1, SASR_IDX_THR_HI, 16'h0005);
    pulses(n);
    chk("resyncRise", n, 1);
    apb(1'b1, SASR_IDX_THR_LO, 16'h00C0);
    cyc(2);
    chk("thrOrder", {27'h0, thr}, 32'h0E);
    apb(1'b1, SASR_IDX_THR_HI, 16'h0005);
    pulses(n);
    chk("resyncLevel", n, 0);
    apb(1'b1, SASR_IDX_THR_HI, 16'h0001);
    apb(1'b1, SASR_IDX_THR_HI, 16'h0005);
    pulses(n);
    chk("resyncAgain", n, 1);
    $display("test threshold done");
  endtask

  task automatic t_irq;
    rdchk("irqSticky", SASR_IDX_IRQ_STAT, 32'hCF);
    chk("irqMaskedOff", {31'h0, irq}, 32'h0);
    apb(1'b1, SASR_IDX_IRQ_STAT, 16'h00FF);
    rdchk("irqClr", SASR_IDX_IRQ_STAT, 32'h0);
    apb(1'b1, SASR_IDX_IRQ_MASK, 16'h0004);
    octOv <= 1'b1;
    cyc(1);
    octOv <= 1'b0;
    octOos <= 1'b1;
    cyc(3);
    chk("irqOn", {31'h0, irq}, 32'h1);
    rdchk("irqStat", SASR_IDX_IRQ_STAT, 32'h0C);
    apb(1'b1, SASR_IDX_IRQ_MASK, 16'h0000);
    cyc(2);
    chk("irqMasked", {31'h0, irq}, 32'h0);
    apb(1'b1, SASR_IDX_IRQ_MASK, 16'h0004);
    apb(1'b1, SASR_IDX_IRQ_STAT, 16'h0004);
    cyc(2);
    chk("irqW1c", {31'h0, irq}, 32'h0);
    apb(1'b1, SASR_IDX_IRQ_STAT, 16'h0008);
    rdchk("irqSetWins", SASR_IDX_IRQ_STAT, 32'h08);
    octOos <= 1'b0;
    apb(1'b0, 20'h30A20, 16'h0000);
    chk("unmappedErr", {31'h0, err}, 32'h1);
    chk("unmappedRd", rd, 32'h0);
    $display("test interrupt done");
  endtask

  task automatic t_midreset;
    apb(1'b1, SASR_IDX_CLKSEL, 16'h00FF);
    apb(1'b1, SASR_IDX_IRQ_MASK, 16'h00FF);
    octOos <= 1'b1;
    cyc(3);
    chk("preReset", {23'h0, clkSel, irq}, {23'h0, 8'hFF, 1'b1});
    arstN <= 1'b0;
    octOos <= 1'b0;
    cyc(2);
    chk("inReset", {17'h0, clkSel, thr, resync, irq}, 32'h0);
    chk("inReset2", {8'h0, laneEn, grpSize}, 32'h0);
    arstN <= 1'b1;
    rdchk("afterReset", SASR_IDX_CLKSEL, 32'h0);
    rdchk("thrAfter", SASR_IDX_THR_HI, 32'h0);
    $display("test mid-run reset done");
  endtask

  initial
  begin
    repeat (4) @(posedge refClk);
    arstN <= 1'b1;
    t_reset();
    t_status();
    t_clk();
    t_thr();
    t_irq();
    t_midreset();
    results();
  end
endmodule
`default_nettype wire
